// ===== core/ifs_i2c_flash_slave.sv
/*
  i2c slave write and erase front end for the user flash array.
  assumes scl/sda arrive asynchronously, link_clk oversamples them many times
  per scl bit, and the flash array raises flash_busy the cycle after a strobe.
*/
// How it works
// - 4 kbit: address bit A0 is byte address bit eight
// - 8 kbit: A0 bit eight, A1 bit nine
// - acknowledge slave address only on own match
// - byte write: address, byte address, data, acknowledges
// - programming starts only after the stop condition
// - ignore new transfers while internal write runs
// - page write with build-time page of 8/16/32
// - no acknowledge to polling while write is busy
// - write protect covers whole array or upper half
// - protected: acknowledge addresses, refuse first data byte
// - read-only build has no erase path
// - exactly one of four erase methods at build
// - upper match plus 111 selects full erase
// - full erase clears both sectors after stop
// - protected: full erase address not acknowledged
// - trigger address write erases sector then programs byte
// - default triggers zero and half memory size
// - address bit 2 selects sector erase in that mode
// - byte address picks sector, erase after stop
// - last slave address bit gives direction, 1 read
// - upper address bits at build, low bits from pins
// - protected: trigger byte address not acknowledged
`timescale 1ns/1ps
module ifs_i2c_flash_slave #(
  parameter int MEM_KBITS = ifs_pkg::MEM_KBITS_DEF,
  parameter int PAGE_BYTES = ifs_pkg::PAGE_BYTES_DEF,
  parameter ifs_pkg::ifs_erase_t ERASE_MODE = ifs_pkg::ERASE_FULL,
  parameter bit WP_UPPER_HALF = 1'b0,
  parameter bit READ_ONLY = 1'b0,
  parameter logic [3:0] SLAVE_UPPER = ifs_pkg::SLAVE_UPPER_DEF,
  parameter logic [9:0] TRIG0 = ifs_pkg::TRIG0_DEF,
  parameter logic [9:0] TRIG1 = 10'(MEM_KBITS * ifs_pkg::BYTES_PER_KBIT / 2)
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link oversampling clock
  input wire logic link_clk,
  // i2c pins, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // device select pins and write protect
  input wire logic [2:0] dev_sel,
  input wire logic write_protect,
  // flash array side
  output ifs_pkg::ifs_flash_req_t flash_req,
  input wire logic flash_busy,
  // status
  output logic write_busy
);
  localparam logic [9:0] HALF_ADDR = 10'(MEM_KBITS * ifs_pkg::BYTES_PER_KBIT / 2);
  localparam logic [9:0] PMASK = 10'(PAGE_BYTES - 1);
  localparam logic [4:0] PAGE_LAST = 5'(PAGE_BYTES - 1);
  // read-only builds lose every erase path
  localparam ifs_pkg::ifs_erase_t EMODE = READ_ONLY ? ifs_pkg::ERASE_NONE : ERASE_MODE;

  // ==========================================================
  // helper functions
  // true when the byte address lies in the write-protected range
  function automatic logic in_protect(input logic [9:0] a);
    in_protect = WP_UPPER_HALF ? (a >= HALF_ADDR) : 1'b1;
  endfunction
  // sector holding a byte address: upper half is sector 1
  function automatic logic sector_of(input logic [9:0] a);
    sector_of = (a >= HALF_ADDR);
  endfunction
  // classify a received slave address byte
  function automatic ifs_pkg::ifs_kind_t slave_kind(input logic [7:0] b, input logic [2:0] d);
    logic [2:0] cmp;
    logic upper_ok;
    logic low_ok;
    // low bits reused as memory address or erase select are not compared
    cmp = 3'h7;
    if (MEM_KBITS >= 4) begin
      cmp[0] = 1'b0;
    end
    if (MEM_KBITS == 8) begin
      cmp[1] = 1'b0;
    end
    if (EMODE == ifs_pkg::ERASE_A2) begin
      cmp[2] = 1'b0;
    end
    upper_ok = (b[7:4] == SLAVE_UPPER);
    low_ok = (((b[3:1] ^ d) & cmp) == 3'h0);
    slave_kind = ifs_pkg::KIND_NONE;
    if (upper_ok && low_ok && !(EMODE == ifs_pkg::ERASE_A2 && b[3])) begin
      slave_kind = ifs_pkg::KIND_RW;
    end else if (upper_ok && EMODE == ifs_pkg::ERASE_FULL &&
                 b[3:1] == ifs_pkg::FULL_ERASE_LOW) begin
      slave_kind = ifs_pkg::KIND_FULL;
    end else if (upper_ok && low_ok && EMODE == ifs_pkg::ERASE_A2) begin
      slave_kind = ifs_pkg::KIND_SECTOR;
    end
  endfunction

  // ==========================================================
  // link domain: reset release and input synchronisers
  logic [1:0] lrst_reg;         // reset release shifter
  logic link_rst_n;             // link-domain reset, released on link_clk
  logic [6:0] in_meta_reg;      // first stage, read only by the second
  logic [6:0] in_sync_reg;      // {ack, wp, dev[2:0], sda, scl}
  logic scl_d_reg;              // previous synced scl
  logic sda_d_reg;              // previous synced sda
  logic ack_tgl_reg;            // flash-domain done toggle

  // async assert, release on the link clock
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_reg <= 2'b00;
    end else begin
      lrst_reg <= {lrst_reg[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_reg[1];

  // two flops on everything that enters from outside link_clk
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_meta_reg <= 7'h03;
      in_sync_reg <= 7'h03;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      in_meta_reg <= {ack_tgl_reg, write_protect, dev_sel, sda_in, scl_in};
      in_sync_reg <= in_meta_reg;
      scl_d_reg <= in_sync_reg[0];
      sda_d_reg <= in_sync_reg[1];
    end
  end

  logic scl_s, sda_s, wp_s, ack_s;
  logic [2:0] dev_s;
  assign scl_s = in_sync_reg[0];
  assign sda_s = in_sync_reg[1];
  assign dev_s = in_sync_reg[4:2];
  assign wp_s = in_sync_reg[5];
  assign ack_s = in_sync_reg[6];

  // bus conditions seen in the synced samples
  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;

  // ==========================================================
  // link domain: bit counter and shifter
  ifs_pkg::ifs_lstate_t state_reg;
  logic [3:0] bit_cnt_reg;      // 0..8 data bits, 9 during acknowledge
  logic [7:0] shreg_reg;        // received byte, msb first
  logic eval;                   // byte complete, decide acknowledge
  assign eval = scl_fall && (bit_cnt_reg == ifs_pkg::LAST_DATA_BIT);

  // count bits on scl rise, open the ack slot and close it on scl fall
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 4'h0;
      shreg_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (state_reg != ifs_pkg::L_IDLE) begin
      if (scl_rise && bit_cnt_reg < ifs_pkg::LAST_DATA_BIT) begin
        shreg_reg <= {shreg_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (eval) begin
        bit_cnt_reg <= ifs_pkg::ACK_SLOT;
      end else if (scl_fall && bit_cnt_reg == ifs_pkg::ACK_SLOT) begin
        bit_cnt_reg <= 4'h0;
      end
    end
  end

  // ==========================================================
  // link domain: acknowledge decision for a complete byte
  logic req_tgl_reg;            // link-domain request toggle
  logic busy_link;              // a command is still with the flash side
  logic [1:0] addr_hi_reg;      // byte address bits eight and nine
  logic [9:0] addr_reg;         // current byte address
  logic op_full_reg, op_sector_reg, wr_any_reg, sector_reg;
  logic ack_ok;
  logic go_data, go_baddr, set_full, set_sector, store;
  ifs_pkg::ifs_lstate_t nxt_state;
  ifs_pkg::ifs_kind_t kind;
  logic [9:0] baddr;

  assign busy_link = req_tgl_reg ^ ack_s;
  assign baddr = {addr_hi_reg, shreg_reg};

  always_comb begin
    ack_ok = 1'b0;
    nxt_state = ifs_pkg::L_SKIP;
    go_baddr = 1'b0;
    go_data = 1'b0;
    set_full = 1'b0;
    set_sector = 1'b0;
    store = 1'b0;
    kind = slave_kind(shreg_reg, dev_s);
    unique case (state_reg)
      ifs_pkg::L_SLAVE: begin
        // busy: every address refused, polling included
        if (!busy_link) begin
          unique case (kind)
            ifs_pkg::KIND_RW: begin
              ack_ok = 1'b1;
              // direction bit 1 is a read: acknowledged, rest of the transfer skipped
              if (!shreg_reg[0]) begin
                nxt_state = ifs_pkg::L_BADDR;
                go_baddr = 1'b1;
              end
            end
            ifs_pkg::KIND_FULL: begin
              // any protect level covers part of the array
              ack_ok = !wp_s;
              set_full = !wp_s;
            end
            ifs_pkg::KIND_SECTOR: begin
              ack_ok = 1'b1;
              nxt_state = ifs_pkg::L_BADDR;
              go_baddr = 1'b1;
            end
            ifs_pkg::KIND_NONE: begin
              ack_ok = 1'b0;
            end
          endcase
        end
      end
      ifs_pkg::L_BADDR: begin
        if (op_sector_reg) begin
          // any address in the sector names it
          ack_ok = !(wp_s && in_protect(baddr));
          set_sector = ack_ok;
        end else if (EMODE == ifs_pkg::ERASE_TRIG && wp_s && in_protect(baddr) &&
                     (baddr == TRIG0 || baddr == TRIG1)) begin
          ack_ok = 1'b0;
        end else begin
          ack_ok = 1'b1;
          nxt_state = ifs_pkg::L_DATA;
        end
      end
      ifs_pkg::L_DATA: begin
        // protected or read-only: refuse the data byte
        if (!READ_ONLY && !(wp_s && in_protect(addr_reg))) begin
          ack_ok = 1'b1;
          nxt_state = ifs_pkg::L_DATA;
          store = 1'b1;
          go_data = 1'b1;
        end
      end
      ifs_pkg::L_IDLE, ifs_pkg::L_SKIP: begin
        ack_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // link domain: transfer phase, address and pending operation
  logic [4:0] off;              // page offset of the current address
  assign off = 5'(addr_reg & PMASK);

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg <= ifs_pkg::L_IDLE;
      addr_hi_reg <= 2'b00;
      addr_reg <= 10'h000;
      op_full_reg <= 1'b0;
      op_sector_reg <= 1'b0;
      wr_any_reg <= 1'b0;
      sector_reg <= 1'b0;
    end else if (start_det) begin
      // repeated start behaves as start and drops unfinished work
      state_reg <= ifs_pkg::L_SLAVE;
      op_full_reg <= 1'b0;
      op_sector_reg <= 1'b0;
      wr_any_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ifs_pkg::L_IDLE;
    end else if (eval) begin
      state_reg <= nxt_state;
      if (state_reg == ifs_pkg::L_SLAVE) begin
        addr_hi_reg[0] <= (MEM_KBITS >= 4) ? shreg_reg[1] : 1'b0;
        addr_hi_reg[1] <= (MEM_KBITS == 8) ? shreg_reg[2] : 1'b0;
        op_full_reg <= set_full;
        op_sector_reg <= (kind == ifs_pkg::KIND_SECTOR) && go_baddr;
      end
      if (state_reg == ifs_pkg::L_BADDR) begin
        addr_reg <= baddr;
        sector_reg <= sector_of(baddr);
        op_sector_reg <= set_sector;
      end
      if (go_data) begin
        wr_any_reg <= 1'b1;
        // first byte at a trigger address erases its sector first
        if (!wr_any_reg && EMODE == ifs_pkg::ERASE_TRIG &&
            (addr_reg == TRIG0 || addr_reg == TRIG1)) begin
          op_sector_reg <= 1'b1;
        end
        // advance but stay inside the page
        addr_reg <= (addr_reg & ~PMASK) | ((addr_reg + 10'h001) & PMASK);
      end
    end
  end

  // drive acknowledge through the ninth clock, release after it
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe <= ifs_pkg::SDA_OE_RST;
      sda_out <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (eval) begin
      sda_oe <= ack_ok;
    end else if (scl_fall && bit_cnt_reg == ifs_pkg::ACK_SLOT) begin
      sda_oe <= 1'b0;
    end
  end

  // ==========================================================
  // link domain: page buffer, flip-flops indexed by page offset
  logic [7:0] buf_mem [ifs_pkg::BUF_DEPTH];
  logic [ifs_pkg::BUF_DEPTH-1:0] valid_reg;  // offsets written this page

  // wrapped writes land on the same offset, last byte wins
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      valid_reg <= '0;
      for (int i = 0; i < ifs_pkg::BUF_DEPTH; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (start_det && !busy_link) begin
      valid_reg <= '0;
    end else if (eval && store) begin
      buf_mem[off] <= shreg_reg;
      valid_reg[off] <= 1'b1;
    end
  end

  // ==========================================================
  // link domain: hand the command over at stop
  ifs_pkg::ifs_cmd_t cmd_reg;   // stable while the request is pending

  // nothing reaches the flash before the stop condition
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_tgl_reg <= ifs_pkg::TOGGLE_RST;
      cmd_reg <= '0;
    end else if (stop_det && !busy_link &&
                 (op_full_reg || op_sector_reg || wr_any_reg)) begin
      cmd_reg.erase_all <= op_full_reg;
      cmd_reg.erase_sector <= op_sector_reg;
      cmd_reg.sector <= sector_reg;
      cmd_reg.write <= wr_any_reg;
      cmd_reg.page_base <= addr_reg & ~PMASK;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ==========================================================
  // flash domain: request synchroniser
  logic req_meta_reg;           // first stage, read only by the second
  logic req_s_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_meta_reg <= ifs_pkg::TOGGLE_RST;
      req_s_reg <= ifs_pkg::TOGGLE_RST;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_s_reg <= req_meta_reg;
    end
  end

  // ==========================================================
  // flash domain: erase and program sequencer
  ifs_pkg::ifs_mstate_t mstate_reg;
  logic [4:0] idx_reg;          // page offset being programmed
  // cmd_reg and buf_mem are read here only while the request is pending,
  // when the link side holds them still

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mstate_reg <= ifs_pkg::M_IDLE;
      idx_reg <= 5'h00;
      ack_tgl_reg <= ifs_pkg::TOGGLE_RST;
      flash_req <= '0;
    end else begin
      // strobes last one cycle
      flash_req.prog <= 1'b0;
      flash_req.erase_sector <= 1'b0;
      flash_req.erase_all <= 1'b0;
      unique case (mstate_reg)
        ifs_pkg::M_IDLE: begin
          idx_reg <= 5'h00;
          if (req_s_reg != ack_tgl_reg) begin
            if (cmd_reg.erase_all) begin
              flash_req.erase_all <= 1'b1;
              mstate_reg <= ifs_pkg::M_WAIT_E;
            end else if (cmd_reg.erase_sector) begin
              flash_req.erase_sector <= 1'b1;
              flash_req.sector <= cmd_reg.sector;
              mstate_reg <= ifs_pkg::M_WAIT_E;
            end else begin
              mstate_reg <= ifs_pkg::M_PROG;
            end
          end
        end
        ifs_pkg::M_WAIT_E: begin
          // erase ends before the data byte is programmed
          if (!flash_req.erase_all && !flash_req.erase_sector && !flash_busy) begin
            mstate_reg <= cmd_reg.write ? ifs_pkg::M_PROG : ifs_pkg::M_DONE;
          end
        end
        ifs_pkg::M_PROG: begin
          if (valid_reg[idx_reg]) begin
            flash_req.prog <= 1'b1;
            flash_req.addr <= cmd_reg.page_base | 10'(idx_reg);
            flash_req.wdata <= buf_mem[idx_reg];
            mstate_reg <= ifs_pkg::M_WAIT_P;
          end else if (idx_reg == PAGE_LAST) begin
            mstate_reg <= ifs_pkg::M_DONE;
          end else begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        ifs_pkg::M_WAIT_P: begin
          if (!flash_req.prog && !flash_busy) begin
            if (idx_reg == PAGE_LAST) begin
              mstate_reg <= ifs_pkg::M_DONE;
            end else begin
              idx_reg <= idx_reg + 5'h01;
              mstate_reg <= ifs_pkg::M_PROG;
            end
          end
        end
        ifs_pkg::M_DONE: begin
          // hand completion back; polling is acknowledged after this
          ack_tgl_reg <= req_s_reg;
          mstate_reg <= ifs_pkg::M_IDLE;
        end
        default: begin
          mstate_reg <= ifs_pkg::M_IDLE;
        end
      endcase
    end
  end

  // busy while a command is pending or running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_busy <= 1'b0;
    end else begin
      write_busy <= (mstate_reg != ifs_pkg::M_IDLE) || (req_s_reg != ack_tgl_reg);
    end
  end
endmodule

// ===== core/ifs_pkg.sv
/*
  shared constants and types of the i2c flash slave front end.
  assumes a single user flash array of at most 8 kbit behind the front end.
*/
package ifs_pkg;
  // ==========================================================
  // sizes
  localparam int ADDR_W = 10;           // widest byte address (8 kbit)
  localparam int IDX_W = 5;             // page buffer index width
  localparam int BUF_DEPTH = 32;        // largest page in bytes
  localparam int BYTES_PER_KBIT = 128;  // 1024 bits / 8
  localparam int MEM_KBITS_DEF = 8;     // default memory size in kbit
  localparam int PAGE_BYTES_DEF = 16;   // default page size (8, 16 or 32)
  // ==========================================================
  // slave address and bit timing
  localparam logic [3:0] SLAVE_UPPER_DEF = 4'ha; // upper four address bits
  localparam logic [2:0] FULL_ERASE_LOW = 3'h7;  // low bits of erase address
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;   // count after eight bits
  localparam logic [3:0] ACK_SLOT = 4'h9;        // count in the ninth clock
  localparam logic [9:0] TRIG0_DEF = 10'h000;    // sector 0 trigger address
  // ==========================================================
  // reset values
  localparam logic SDA_OE_RST = 1'b0;
  localparam logic TOGGLE_RST = 1'b0;
  // ==========================================================
  // build-time erase method
  typedef enum logic [1:0] {
    ERASE_FULL = 2'b00,   // reserved slave address erases all
    ERASE_TRIG = 2'b01,   // write to trigger byte address erases sector
    ERASE_A2 = 2'b10,     // slave address bit 2 selects sector erase
    ERASE_NONE = 2'b11    // no erase path at all
  } ifs_erase_t;
  // slave address decode result
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_RW = 2'b01,
    KIND_FULL = 2'b10,
    KIND_SECTOR = 2'b11
  } ifs_kind_t;
  // link-side transfer phase
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_SLAVE = 3'b001,
    L_BADDR = 3'b010,
    L_DATA = 3'b011,
    L_SKIP = 3'b100
  } ifs_lstate_t;
  // flash-side sequencer
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_WAIT_E = 3'b001,
    M_PROG = 3'b010,
    M_WAIT_P = 3'b011,
    M_DONE = 3'b100
  } ifs_mstate_t;
  // command handed from link domain to flash domain at stop
  typedef struct packed {
    logic erase_all;
    logic erase_sector;
    logic sector;
    logic write;
    logic [ADDR_W-1:0] page_base;
  } ifs_cmd_t;
  // strobes and operands toward the flash array
  typedef struct packed {
    logic prog;
    logic erase_sector;
    logic erase_all;
    logic sector;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } ifs_flash_req_t;
endpackage

// ===== dv/ifs_i2c_master_model.sv
/* i2c bus master model for the flash slave.
   assumes a pull-up on sda: the bench ands the release with the slave's pull. */
`timescale 1ns/1ps
module ifs_i2c_master_model (
  // bus pins, sda high means released
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  localparam int HALF = 400; // ns, far above the slave's sampling lag
  // ==========================================================
  // bus idle at time zero
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda = 1'b0;
    #HALF scl = 1'b0;
  endtask
  // stop: sda rises while scl is high
  task automatic stop();
    sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask
  // eight bits msb first, then a released ninth clock for the answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda = (i < 0) ? 1'b1 : b[i];
      #HALF scl = 1'b1;
      ack = ~sda_line;
      #HALF scl = 1'b0;
    end
  endtask
  // repeat start plus address until acknowledged, bounded
  task automatic poll(input logic [7:0] a, output int tries);
    logic ack;
    tries = 0;
    ack = 1'b0;
    while (!ack && tries < 200) begin
      start();
      wbyte(a, ack);
      tries++;
    end
    stop();
  endtask
endmodule

// ===== dv/ifs_i2c_flash_slave_assertions.sv
/* assertions on the ports of the i2c flash slave.
   assumes the bench changes write_protect only while the block is idle. */
`timescale 1ns/1ps
module ifs_i2c_flash_slave_assertions #(
  parameter ifs_pkg::ifs_erase_t ERASE_MODE = ifs_pkg::ERASE_FULL,
  parameter bit READ_ONLY = 1'b0
) (
  // clocks and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic write_protect,
  // flash side
  input wire ifs_pkg::ifs_flash_req_t flash_req,
  input wire logic flash_busy,
  input wire logic write_busy
);
  // ==========================================================
  // any strobe toward the array
  wire logic strobe = flash_req.prog | flash_req.erase_sector | flash_req.erase_all;
  wire logic erasing = flash_req.erase_sector | flash_req.erase_all;
  sequence strobe_s;
    strobe;
  endsequence
  sequence ack_rise_s;
    $rose(sda_oe);
  endsequence
  pulse_one_a: assert property (@(posedge mclk) disable iff (!reset_n) strobe_s |=> !strobe)
    else $error("strobe longer than one cycle");
  one_kind_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $onehot0({flash_req.prog, flash_req.erase_sector, flash_req.erase_all}))
    else $error("two strobe kinds at once");
  busy_gap_a: assert property (@(posedge mclk) disable iff (!reset_n) strobe_s |-> !$past(flash_busy))
    else $error("strobe while array busy");
  strobe_busy_a: assert property (@(posedge mclk) disable iff (!reset_n) strobe_s |-> write_busy)
    else $error("strobe without write_busy");
  after_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(write_busy) |-> scl_in && sda_in)
    else $error("work began before bus stop");
  no_erase_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !((READ_ONLY || ERASE_MODE == ifs_pkg::ERASE_NONE) && erasing))
    else $error("erase in a build without erase");
  wp_erase_a: assert property (@(posedge mclk) disable iff (!reset_n)
    flash_req.erase_all |-> !write_protect)
    else $error("full erase while protected");
  ack_scl_low_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  ack_hold_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    ack_rise_s |-> ##1 sda_oe [*8])
    else $error("acknowledge dropped early");
  busy_nack_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    write_busy |-> !$rose(sda_oe))
    else $error("acknowledge while busy");
endmodule
bind ifs_i2c_flash_slave ifs_i2c_flash_slave_assertions #(
  .ERASE_MODE(ERASE_MODE), .READ_ONLY(READ_ONLY)) ifs_i2c_flash_slave_assertions_inst (
  .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .write_protect(write_protect), .flash_req(flash_req),
  .flash_busy(flash_busy), .write_busy(write_busy));

// ===== dv/tb_top.sv
/* self-checking bench of the i2c flash slave, default build (8 kbit, page 16).
   assumes the master model and a busy-timer array model stand at the pins. */
`timescale 1ns/1ps
module tb_top;
  logic mclk, link_clk, reset_n, flash_busy, write_protect, sda_oe, sda_out, write_busy;
  logic scl, sda_m;
  logic [2:0] dev_sel;
  ifs_pkg::ifs_flash_req_t flash_req;
  int errors, n_checks, n_erase, busy_cnt;
  logic [17:0] progs[$]; // programmed address and data, in order
  wire logic sda_line = sda_m & ~sda_oe; // open drain with pull-up
  ifs_i2c_master_model m (.scl(scl), .sda(sda_m), .sda_line(sda_line));
  ifs_i2c_flash_slave ifs_i2c_flash_slave_inst (.mclk(mclk), .reset_n(reset_n),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_sel(dev_sel), .write_protect(write_protect), .flash_req(flash_req),
    .flash_busy(flash_busy), .write_busy(write_busy));
  // ==========================================================
  // clocks, link clock offset so the phases stay unrelated
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // array model: busy from the cycle after any strobe, long enough to poll
  always @(negedge mclk) begin
    if (flash_req.prog || flash_req.erase_sector || flash_req.erase_all) busy_cnt = 600;
    else if (busy_cnt > 0) busy_cnt = busy_cnt - 1;
    flash_busy = (busy_cnt > 0);
  end
  always @(posedge mclk) begin
    if (flash_req.prog) progs.push_back({flash_req.addr, flash_req.wdata});
    if (flash_req.erase_all) n_erase++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // foreign address refused, read direction of own address taken
  task automatic t_addr();
    logic ack;
    m.start();
    m.wbyte(8'ha8, ack);
    check(ack, 1'b0);
    m.start();
    m.wbyte(8'hb0, ack);
    check(ack, 1'b0);
    m.start();
    m.wbyte(8'ha1, ack);
    check(ack, 1'b1);
    check(sda_out, 1'b0);
    m.stop();
  endtask
  // full erase by the reserved address, polled until done
  task automatic t_erase();
    logic ack;
    int tries;
    m.start();
    m.wbyte(8'hae, ack);
    check(ack, 1'b1);
    m.stop();
    m.poll(8'ha1, tries);
    check(tries > 1 && tries < 200, 1'b1);
    check(n_erase, 1);
  endtask
  // page write across the page end, upper byte address bits from the slave address
  task automatic t_page();
    logic ack;
    int tries;
    progs.delete();
    m.start();
    m.wbyte(8'ha6, ack);
    m.wbyte(8'hfe, ack);
    m.wbyte(8'h11, ack);
    m.wbyte(8'h22, ack);
    m.wbyte(8'h33, ack);
    check(ack, 1'b1);
    check(progs.size(), 0);
    m.stop();
    m.poll(8'ha1, tries);
    check(tries > 1 && tries < 200, 1'b1);
    check(progs.size(), 3);
    check(progs[0], {10'h3f0, 8'h33});
    check(progs[1], {10'h3fe, 8'h11});
    check(progs[2], {10'h3ff, 8'h22});
  endtask
  // protected array: addresses taken, data and full erase refused
  task automatic t_protect();
    logic ack;
    @(negedge mclk) write_protect = 1'b1;
    m.start();
    m.wbyte(8'ha0, ack);
    check(ack, 1'b1);
    m.wbyte(8'h10, ack);
    check(ack, 1'b1);
    m.wbyte(8'h55, ack);
    check(ack, 1'b0);
    m.start();
    m.wbyte(8'hae, ack);
    check(ack, 1'b0);
    m.stop();
    check(progs.size() + n_erase, 4);
    @(negedge mclk) write_protect = 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the tests need under two hundred microseconds
  initial begin
    #1000000;
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    n_erase = 0;
    write_protect = 1'b0;
    dev_sel = 3'h0;
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    t_addr();
    t_erase(); // the array is cleared before it is written
    t_page();
    t_protect();
    conclude();
  end
endmodule
